/* sim/cru_core_model.sv */
/*
  Behavioural processor core that takes the fast and normal request lines,
  reads the vector of the asserted level and clears the winning source.
  Assumes the bench enables service and chooses a reaction delay in cycles.
*/
`timescale 1ns/10ps

module cru_core_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Request lines and vectors from the unit
  input  wire logic        i_fast,
  input  wire logic        i_normal,
  input  wire logic [4:0]  i_fast_vec,
  input  wire logic [4:0]  i_normal_vec,
  // Bench control
  input  wire logic        i_serve,
  input  wire logic [3:0]  i_delay,
  // Clear towards the sources and a service report
  output logic      [31:0] o_clear,
  output logic             o_served,
  output logic             o_served_fast,
  output logic      [4:0]  o_served_idx
);
  logic [3:0] wait_q;
  logic       seen_q;

  // Service loop; the blackout lets the registered line settle after a clear
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_clear       <= 32'h0;
      o_served      <= 1'b0;
      o_served_fast <= 1'b0;
      o_served_idx  <= 5'h00;
      wait_q        <= 4'h0;
      seen_q        <= 1'b0;
    end
    else
    begin
      o_clear  <= 32'h0;
      o_served <= 1'b0;
      if (wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (i_serve && (i_fast || i_normal))
      begin
        if (!seen_q && i_delay != 4'h0)
        begin
          seen_q <= 1'b1;
          wait_q <= i_delay;
        end
        else
        begin
          seen_q        <= 1'b0;
          wait_q        <= 4'h3;
          o_clear       <= 32'h1 << (i_fast ? i_fast_vec : i_normal_vec);
          o_served      <= 1'b1;
          o_served_fast <= i_fast;
          o_served_idx  <= i_fast ? i_fast_vec : i_normal_vec;
        end
      end
    end
  end
endmodule

/* sim/tb.sv */
/*
  Self-checking bench of the central request unit with a core model.
  Assumes the design ports as declared and a 200 MHz clock.
*/
`timescale 1ns/10ps

module tb;
  logic        i_clk;
  logic        i_rst_b;
  logic [31:0] req;
  logic [31:0] en;
  logic [31:0] fsel;
  logic [31:0] clr;
  logic [31:0] pend;
  logic        serve;
  logic [3:0]  dly;
  logic        fl;
  logic        nl;
  logic [4:0]  fv;
  logic [4:0]  nv;
  logic        sv;
  logic        sf;
  logic [4:0]  si;
  int          n_fail;
  int          check_count;
  int          cyc;

  // Request vector fanned out onto the named channel ports
  cru_request_unit DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_brownout_request(req[0]), .i_external_pin_request(req[1]),
    .i_watchdog_expiry_request(req[2]), .i_watchdog_halfway_request(req[3]),
    .i_serial_error_request(req[4]), .i_serial0_receive_request(req[5]),
    .i_serial0_transmit_request(req[6]), .i_serial1_receive_request(req[7]),
    .i_serial1_transmit_request(req[8]), .i_pmbus_request(req[9]),
    .i_digital_comparator_request(req[10]), .i_front_end0_request(req[11]),
    .i_front_end1_request(req[12]), .i_front_end2_request(req[13]),
    .i_timer_pwm3_request(req[14]), .i_timer_pwm2_request(req[15]),
    .i_timer_pwm1_request(req[16]), .i_timer_pwm0_request(req[17]),
    .i_wide_timer_overflow_request(req[18]), .i_dead_time_fault_request(req[19]),
    .i_wide_timer_compare1_request(req[20]), .i_wide_timer_capture0_request(req[21]),
    .i_wide_timer_compare0_request(req[22]), .i_power_current_mode_request(req[23]),
    .i_conversion_done_request(req[24]), .i_fault_mux_request(req[25]),
    .i_pulse_generator3_request(req[26]), .i_pulse_generator2_request(req[27]),
    .i_pulse_generator1_request(req[28]), .i_pulse_generator0_request(req[29]),
    .i_external_fault_request(req[30]), .i_software_system_request(req[31]),
    .i_request_clear(clr), .i_channel_enable(en), .i_fast_select(fsel),
    .o_pending_q(pend), .o_fast_request_level_q(fl), .o_normal_request_level_q(nl),
    .o_fast_vector_q(fv), .o_normal_vector_q(nv)
  );

  cru_core_model core (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_fast(fl), .i_normal(nl),
    .i_fast_vec(fv), .i_normal_vec(nv), .i_serve(serve), .i_delay(dly),
    .o_clear(clr), .o_served(sv), .o_served_fast(sf), .o_served_idx(si)
  );

  // Clock and hang guard; the ceiling is far above the planned run
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One-cycle pulse so level channels do not set again after a clear
  task automatic pulse(input logic [31:0] m);
    @(posedge i_clk);
    req <= m;
    @(posedge i_clk);
    req <= 32'h0;
  endtask

  task automatic set_serve(input logic s);
    @(posedge i_clk);
    serve <= s;
    #1;
  endtask

  // Bounded wait for the next service report, then judge it
  task automatic served(input logic [4:0] idx, input logic f);
    int k;
    for (k = 0; k < 60 && sv !== 1'b1; k++)
      tick(1);
    chk({31'h0, sv}, 32'h1);
    chk({27'h0, si}, {27'h0, idx});
    chk({31'h0, sf}, {31'h0, f});
    tick(1);
  endtask

  task automatic t_reset;
    chk(pend, 32'h0);
    chk({20'h0, fl, nl, fv, nv}, 32'h0);
  endtask

  task automatic t_walk;
    pulse(32'h1 << 17);
    tick(3);
    chk(pend, 32'h0002_0000);
    chk({25'h0, fl, nl, nv}, 32'h0000_0031);
    tick(10);
    chk(pend, 32'h0002_0000);
    set_serve(1'b1);
    served(5'h11, 1'b0);
    tick(4);
    chk({25'h0, fl, nl, nv}, 32'h0000_0011);
    set_serve(1'b0);
  endtask

  // Every channel alone, served by a slow core
  task automatic t_map;
    int n;
    @(posedge i_clk);
    dly <= 4'h3;
    for (n = 0; n < 32; n++)
    begin
      pulse(32'h1 << n);
      tick(6);
      chk(pend, 32'h1 << n);
      set_serve(1'b1);
      served(n[4:0], 1'b0);
      set_serve(1'b0);
    end
    @(posedge i_clk);
    dly <= 4'h0;
  endtask

  task automatic t_order;
    int n;
    pulse(32'hFFFF_FFFF);
    tick(6);
    chk(pend, 32'hFFFF_FFFF);
    set_serve(1'b1);
    for (n = 31; n >= 0; n--)
      served(n[4:0], 1'b0);
    set_serve(1'b0);
  endtask

  // Low fast channel beats a higher normal one; 31 beats the fault pin
  task automatic t_fast;
    @(posedge i_clk);
    fsel <= 32'hC000_0008;
    pulse(32'hC010_0008);
    tick(5);
    chk({25'h0, fl, nl, fv}, 32'h0000_005F);
    set_serve(1'b1);
    served(5'h1F, 1'b1);
    served(5'h1E, 1'b1);
    served(5'h03, 1'b1);
    served(5'h14, 1'b0);
    set_serve(1'b0);
    @(posedge i_clk);
    fsel <= 32'h0;
  endtask

  // Masked channel latches but stays out of the line until enabled
  task automatic t_mask;
    @(posedge i_clk);
    en <= ~(32'h1 << 25);
    pulse(32'h0200_0400);
    tick(5);
    chk(pend, 32'h0200_0400);
    chk({25'h0, fl, nl, nv}, 32'h0000_002A);
    set_serve(1'b1);
    served(5'h0A, 1'b0);
    tick(6);
    chk({nl, pend[30:0]}, 32'h0200_0000);
    @(posedge i_clk);
    en <= 32'hFFFF_FFFF;
    served(5'h19, 1'b0);
    set_serve(1'b0);
  endtask

  task automatic complete_run;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    i_rst_b = 1'b0;
    req = 32'h0;
    en = 32'hFFFF_FFFF;
    fsel = 32'h0;
    serve = 1'b0;
    dly = 4'h0;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tick(1);
    t_reset();
    t_walk();
    t_map();
    t_order();
    t_fast();
    t_mask();
    complete_run();
  end
endmodule

/* src/cru_defines.svh */
/*
  Constants of the central request unit: channel count, vector width and the
  fixed channel numbers of every peripheral request.
  Assumes it is included by bare name from the package and the request unit.
*/
`ifndef CRU_DEFINES_SVH
`define CRU_DEFINES_SVH

// Channel count and vector index width
`define CRU_NUM_CHANNELS   32
`define CRU_INDEX_WIDTH    5

// Reset values
`define CRU_PENDING_RESET  32'h0000_0000
`define CRU_INDEX_RESET    5'h00

// Channel numbers, precedence rising with the number
`define CRU_CH_BROWNOUT        0
`define CRU_CH_EXT_PIN         1
`define CRU_CH_WD_EXPIRY       2
`define CRU_CH_WD_HALFWAY      3
`define CRU_CH_SERIAL_ERR      4
`define CRU_CH_SERIAL0_RX      5
`define CRU_CH_SERIAL0_TX      6
`define CRU_CH_SERIAL1_RX      7
`define CRU_CH_SERIAL1_TX      8
`define CRU_CH_PMBUS           9
`define CRU_CH_DIG_COMP        10
`define CRU_CH_FRONT_END0      11
`define CRU_CH_FRONT_END1      12
`define CRU_CH_FRONT_END2      13
`define CRU_CH_TIMER_PWM3      14
`define CRU_CH_TIMER_PWM2      15
`define CRU_CH_TIMER_PWM1      16
`define CRU_CH_TIMER_PWM0      17
`define CRU_CH_WIDE_OVERFLOW   18
`define CRU_CH_DEAD_TIME_FAULT 19
`define CRU_CH_WIDE_COMPARE1   20
`define CRU_CH_WIDE_CAPTURE0   21
`define CRU_CH_WIDE_COMPARE0   22
`define CRU_CH_POWER_CURRENT   23
`define CRU_CH_CONV_DONE       24
`define CRU_CH_FAULT_MUX       25
`define CRU_CH_PULSE_GEN3      26
`define CRU_CH_PULSE_GEN2      27
`define CRU_CH_PULSE_GEN1      28
`define CRU_CH_PULSE_GEN0      29
`define CRU_CH_EXT_FAULT       30
`define CRU_CH_SOFTWARE        31

`endif

/* src/cru_pkg.sv */
/*
  Types of the central request unit: the packed state of the top module.
  Assumes the constants header is on the include path.
*/
`include "cru_defines.svh"

package cru_pkg;

  // Whole state of the request unit, registered in one process
  typedef struct packed {
    logic [`CRU_NUM_CHANNELS-1:0] pending;
    logic [1:0]                   pin_meta;
    logic [1:0]                   pin_sync;
    logic [1:0]                   pin_last;
    logic                         fast;
    logic                         normal;
    logic [`CRU_INDEX_WIDTH-1:0]  fast_vec;
    logic [`CRU_INDEX_WIDTH-1:0]  normal_vec;
  } cru_state_t;

endpackage

/* src/cru_request_unit.sv */
/*
  Central request unit: gathers 32 peripheral request channels, keeps each
  pending until its source clears it, and drives a fast and a normal request
  line with a vector index naming the winning channel of each level.
  Assumes all requests except the two pin channels come from logic on i_clk;
  masks and level selects are held by surrounding logic on the same clock.
  // Contract
  // - Track 32 channels pending independently
  // - Fast and normal levels, fast wins
  // - Readable vector index per level
  // - Index names highest pending channel
  // - Precedence rises with channel number
  // - Each channel masked on its own
  // - Channels 0 to 3: brownout, pin, watchdog
  // - Channels 4 to 8: serial ports
  // - Channels 11 to 13: front ends
  // - Channels 14 to 17: timer pulse units
  // - Channel 18: wide timer overflow
  // - Channel 19: dead time fault
  // - Channels 20 to 22: wide timer events
  // - Channel 23: power current mode switch
  // - Channel 24: conversion done
  // - Channel 25: fault multiplexer events
  // - Channels 26 to 29: pulse generators
*/
`timescale 1ns/10ps
`include "cru_defines.svh"

module cru_request_unit
  import cru_pkg::*;
#(
  parameter int NCH = `CRU_NUM_CHANNELS,
  parameter int IW  = `CRU_INDEX_WIDTH
) (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_b,
  // Low channels, pin requests arrive asynchronously
  input  wire logic           i_brownout_request,
  input  wire logic           i_external_pin_request,
  input  wire logic           i_watchdog_expiry_request,
  input  wire logic           i_watchdog_halfway_request,
  // Serial ports
  input  wire logic           i_serial_error_request,
  input  wire logic           i_serial0_receive_request,
  input  wire logic           i_serial0_transmit_request,
  input  wire logic           i_serial1_receive_request,
  input  wire logic           i_serial1_transmit_request,
  // Bus and converter events
  input  wire logic           i_pmbus_request,
  input  wire logic           i_digital_comparator_request,
  input  wire logic           i_front_end0_request,
  input  wire logic           i_front_end1_request,
  input  wire logic           i_front_end2_request,
  // Timers
  input  wire logic           i_timer_pwm3_request,
  input  wire logic           i_timer_pwm2_request,
  input  wire logic           i_timer_pwm1_request,
  input  wire logic           i_timer_pwm0_request,
  input  wire logic           i_wide_timer_overflow_request,
  input  wire logic           i_dead_time_fault_request,
  input  wire logic           i_wide_timer_compare1_request,
  input  wire logic           i_wide_timer_capture0_request,
  input  wire logic           i_wide_timer_compare0_request,
  // Power stage and faults
  input  wire logic           i_power_current_mode_request,
  input  wire logic           i_conversion_done_request,
  input  wire logic           i_fault_mux_request,
  input  wire logic           i_pulse_generator3_request,
  input  wire logic           i_pulse_generator2_request,
  input  wire logic           i_pulse_generator1_request,
  input  wire logic           i_pulse_generator0_request,
  input  wire logic           i_external_fault_request,
  input  wire logic           i_software_system_request,
  // Per-channel clear from each source, mask and level select
  input  wire logic [NCH-1:0] i_request_clear,
  input  wire logic [NCH-1:0] i_channel_enable,
  input  wire logic [NCH-1:0] i_fast_select,
  // Pending view and the two request levels
  output logic      [NCH-1:0] o_pending_q,
  output logic                o_fast_request_level_q,
  output logic                o_normal_request_level_q,
  output logic      [IW-1:0]  o_fast_vector_q,
  output logic      [IW-1:0]  o_normal_vector_q
);

  cru_state_t state_q;
  cru_state_t state_d;

  logic [NCH-1:0] req_vec;
  logic [NCH-1:0] enabled_pending;
  logic [NCH-1:0] fast_cand;
  logic [NCH-1:0] normal_cand;
  logic [IW-1:0]  fast_idx;
  logic [IW-1:0]  normal_idx;
  logic           fast_any;
  logic           normal_any;
  logic [1:0]     pin_rise;

  // Pin channels only ever count their rising edge, seen after two flops
  assign pin_rise = state_q.pin_sync & ~state_q.pin_last;

  // Low channels: brownout, pin, watchdog
  always_comb
  begin
    req_vec                          = '0;
    req_vec[`CRU_CH_BROWNOUT]        = i_brownout_request;
    req_vec[`CRU_CH_EXT_PIN]         = pin_rise[0];
    req_vec[`CRU_CH_WD_EXPIRY]       = i_watchdog_expiry_request;
    req_vec[`CRU_CH_WD_HALFWAY]      = i_watchdog_halfway_request;
    // Serial ports share one error channel
    req_vec[`CRU_CH_SERIAL_ERR]      = i_serial_error_request;
    req_vec[`CRU_CH_SERIAL0_RX]      = i_serial0_receive_request;
    req_vec[`CRU_CH_SERIAL0_TX]      = i_serial0_transmit_request;
    req_vec[`CRU_CH_SERIAL1_RX]      = i_serial1_receive_request;
    req_vec[`CRU_CH_SERIAL1_TX]      = i_serial1_transmit_request;
    // Bus and comparator
    req_vec[`CRU_CH_PMBUS]           = i_pmbus_request;
    req_vec[`CRU_CH_DIG_COMP]        = i_digital_comparator_request;
    // Front ends: each OR of its own six events upstream
    req_vec[`CRU_CH_FRONT_END0]      = i_front_end0_request;
    req_vec[`CRU_CH_FRONT_END1]      = i_front_end1_request;
    req_vec[`CRU_CH_FRONT_END2]      = i_front_end2_request;
    // Timer pulse units in reverse order
    req_vec[`CRU_CH_TIMER_PWM3]      = i_timer_pwm3_request;
    req_vec[`CRU_CH_TIMER_PWM2]      = i_timer_pwm2_request;
    req_vec[`CRU_CH_TIMER_PWM1]      = i_timer_pwm1_request;
    req_vec[`CRU_CH_TIMER_PWM0]      = i_timer_pwm0_request;
    req_vec[`CRU_CH_WIDE_OVERFLOW]   = i_wide_timer_overflow_request;
    req_vec[`CRU_CH_DEAD_TIME_FAULT] = i_dead_time_fault_request;
    req_vec[`CRU_CH_WIDE_COMPARE1]   = i_wide_timer_compare1_request;
    req_vec[`CRU_CH_WIDE_CAPTURE0]   = i_wide_timer_capture0_request;
    req_vec[`CRU_CH_WIDE_COMPARE0]   = i_wide_timer_compare0_request;
    // Mode detail stays in the power current unit's own flag
    req_vec[`CRU_CH_POWER_CURRENT]   = i_power_current_mode_request;
    req_vec[`CRU_CH_CONV_DONE]       = i_conversion_done_request;
    req_vec[`CRU_CH_FAULT_MUX]       = i_fault_mux_request;
    // Pulse generators in reverse order
    req_vec[`CRU_CH_PULSE_GEN3]      = i_pulse_generator3_request;
    req_vec[`CRU_CH_PULSE_GEN2]      = i_pulse_generator2_request;
    req_vec[`CRU_CH_PULSE_GEN1]      = i_pulse_generator1_request;
    req_vec[`CRU_CH_PULSE_GEN0]      = i_pulse_generator0_request;
    // Fault pin and software request at top precedence
    req_vec[`CRU_CH_EXT_FAULT]       = pin_rise[1];
    req_vec[`CRU_CH_SOFTWARE]        = i_software_system_request;
  end

  // Masked channels stay pending but take no part in the race
  assign enabled_pending = state_q.pending & i_channel_enable;
  assign fast_cand       = enabled_pending & i_fast_select;
  assign normal_cand     = enabled_pending & ~i_fast_select;

  // One encoder per level, highest channel number wins
  cru_winner #(
    .W  (NCH),
    .IW (IW)
  ) u_fast_winner (
    .i_cand  (fast_cand),
    .o_index (fast_idx),
    .o_valid (fast_any)
  );

  cru_winner #(
    .W  (NCH),
    .IW (IW)
  ) u_normal_winner (
    .i_cand  (normal_cand),
    .o_index (normal_idx),
    .o_valid (normal_any)
  );

  // Next state: sync pins, latch pending, rank levels
  always_comb
  begin
    state_d          = state_q;
    state_d.pin_meta = {i_external_fault_request, i_external_pin_request};
    state_d.pin_sync = state_q.pin_meta;
    state_d.pin_last = state_q.pin_sync;
    // Set beats a same-cycle clear so no event is lost
    state_d.pending  = (state_q.pending & ~i_request_clear) | req_vec;
    // Fast level masks the normal line while it is up
    state_d.fast     = fast_any;
    state_d.normal   = normal_any & ~fast_any;
    // Index holds its last winner while its level is idle
    if (fast_any)
    begin
      state_d.fast_vec = fast_idx;
    end
    if (normal_any)
    begin
      state_d.normal_vec = normal_idx;
    end
  end

  // Single state register, constants only under reset
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q.pending    <= `CRU_PENDING_RESET;
      state_q.pin_meta   <= 2'h0;
      state_q.pin_sync   <= 2'h0;
      state_q.pin_last   <= 2'h0;
      state_q.fast       <= 1'b0;
      state_q.normal     <= 1'b0;
      state_q.fast_vec   <= `CRU_INDEX_RESET;
      state_q.normal_vec <= `CRU_INDEX_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  assign o_pending_q              = state_q.pending;
  assign o_fast_request_level_q   = state_q.fast;
  assign o_normal_request_level_q = state_q.normal;
  assign o_fast_vector_q          = state_q.fast_vec;
  assign o_normal_vector_q        = state_q.normal_vec;

  // Checks on the registered behaviour
  default clocking cru_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // A pending bit only drops through its own clear
  pend_hold_a: assert property (
    ##1 ((($past(state_q.pending) & ~$past(i_request_clear)) & ~state_q.pending) == '0))
  else $error("pending bit dropped without a clear");

  // Every raised request is pending one edge later
  req_latch_a: assert property (
    ##1 (($past(req_vec) & ~state_q.pending) == '0))
  else $error("request not latched as pending");

  // Fast line follows enabled fast candidates by one edge
  fast_line_a: assert property (
    ##1 (o_fast_request_level_q == (|$past(fast_cand))))
  else $error("fast level does not follow its candidates");

  // Normal line never stands with the fast line
  level_excl_a: assert property (
    o_normal_request_level_q |-> !o_fast_request_level_q)
  else $error("normal level raised beside fast level");

  // Fast index is the top enabled fast candidate
  fast_vec_a: assert property (
    o_fast_request_level_q |->
      (($past(fast_cand) >> o_fast_vector_q) == 32'h0000_0001))
  else $error("fast index is not the highest candidate");

  // Normal index is the top enabled normal candidate
  normal_vec_a: assert property (
    o_normal_request_level_q |->
      (($past(normal_cand) >> o_normal_vector_q) == 32'h0000_0001))
  else $error("normal index is not the highest candidate");

  // Nothing enabled and pending means both lines low
  mask_quiet_a: assert property (
    (enabled_pending == '0) |=> (!o_fast_request_level_q && !o_normal_request_level_q))
  else $error("level raised by a masked channel");

  // A pin edge is pending three edges after it is seen
  pin_edge_a: assert property (
    $rose(i_external_pin_request) |-> ##3 state_q.pending[`CRU_CH_EXT_PIN])
  else $error("external pin edge not pending in time");

  // Software request outranks the fault pin when both are fast candidates
  top_rank_a: assert property (
    (fast_cand[`CRU_CH_SOFTWARE] && fast_cand[`CRU_CH_EXT_FAULT])
      |=> (o_fast_vector_q == 5'h1F))
  else $error("channel 31 did not win");

  // A cleared bit with no fresh request drops at the next edge
  clear_drop_a: assert property (
    ##1 ((($past(state_q.pending) & $past(i_request_clear) & ~$past(req_vec))
      & state_q.pending) == '0))
  else $error("pending bit survived its clear");

  // Normal line rises only while no fast candidate exists
  normal_line_a: assert property (
    ##1 (o_normal_request_level_q == ((|$past(normal_cand)) && !(|$past(fast_cand)))))
  else $error("normal level does not follow its candidates");

  // Fast index keeps its last winner while the level is idle
  fast_hold_a: assert property (
    !(|$past(fast_cand)) |-> (o_fast_vector_q == $past(o_fast_vector_q)))
  else $error("fast index moved while idle");

  // Normal index keeps its last winner while the level is idle
  normal_hold_a: assert property (
    !(|$past(normal_cand)) |-> (o_normal_vector_q == $past(o_normal_vector_q)))
  else $error("normal index moved while idle");

  // A fault pin edge is pending three edges after it is seen
  fault_pin_a: assert property (
    $rose(i_external_fault_request) |-> ##3 state_q.pending[`CRU_CH_EXT_FAULT])
  else $error("fault pin edge not pending in time");

  // Sample wiring checks; plain bit numbers so a slip in the map shows
  brownout_map_a: assert property (
    i_brownout_request |=> o_pending_q[0])
  else $error("brownout request not on channel 0");

  serial_map_a: assert property (
    i_serial1_transmit_request |=> o_pending_q[8])
  else $error("serial1 transmit request not on channel 8");

  front_map_a: assert property (
    i_front_end2_request |=> o_pending_q[13])
  else $error("front end2 request not on channel 13");

  timer_map_a: assert property (
    i_timer_pwm3_request |=> o_pending_q[14])
  else $error("timer pulse unit 3 request not on channel 14");

  overflow_map_a: assert property (
    i_wide_timer_overflow_request |=> o_pending_q[18])
  else $error("wide timer overflow not on channel 18");

  dead_time_map_a: assert property (
    i_dead_time_fault_request |=> o_pending_q[19])
  else $error("dead time fault not on channel 19");

  capture_map_a: assert property (
    i_wide_timer_capture0_request |=> o_pending_q[21])
  else $error("wide timer capture not on channel 21");

  conv_map_a: assert property (
    i_conversion_done_request |=> o_pending_q[24])
  else $error("conversion done not on channel 24");

  pulse_map_a: assert property (
    i_pulse_generator0_request |=> o_pending_q[29])
  else $error("pulse generator0 request not on channel 29");

  software_map_a: assert property (
    i_software_system_request |=> o_pending_q[31])
  else $error("software request not on channel 31");

  // Main scenarios
  fast_pair_c: cover property (fast_cand[`CRU_CH_SOFTWARE] && fast_cand[`CRU_CH_EXT_FAULT]);
  fast_win_c: cover property (o_fast_request_level_q && (o_fast_vector_q == 5'h1F));
  normal_win_c: cover property (o_normal_request_level_q ##1 o_fast_request_level_q);
  set_clear_c: cover property ((req_vec & i_request_clear) != '0);
  pin_fault_c: cover property (state_q.pending[`CRU_CH_EXT_FAULT]);

endmodule

/* src/cru_winner.sv */
/*
  Fixed-precedence encoder: index of the highest set request bit.
  Assumes purely combinational use on one clock domain; no state.
*/
`timescale 1ns/10ps

module cru_winner #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  // Candidate requests
  input  wire logic [W-1:0]  i_cand,
  // Winning channel
  output logic      [IW-1:0] o_index,
  output logic               o_valid
);

  // Later hits overwrite earlier ones, so the highest channel wins
  always_comb
  begin
    o_index = '0;
    o_valid = 1'b0;
    for (int i = 0; i < W; i++)
    begin
      if (i_cand[i])
      begin
        o_index = IW'(i);
        o_valid = 1'b1;
      end
    end
  end

endmodule
